// ---- dsl_pkg.sv ----
// package: constants and types for the serial load control block
package dsl_pkg;
  localparam int WORD_BITS = 24;
  localparam int DAC_BITS = 20;
  localparam int CNT_BITS = 5;
  localparam logic [19:0] DAC_RESET_CODE = 20'h0_0000;
  localparam logic [19:0] CLEAR_RESET_CODE = 20'h0_0000;
  localparam logic [19:0] TWOS_OFFSET = 20'h8_0000;
  typedef enum logic {DSL_CODE_BINARY, DSL_CODE_TWOS} dsl_coding_t;
endpackage : dsl_pkg

// ---- dsl_sync_if.sv ----
// interface: synchronised pin levels and edge pulses
`timescale 1ns/10ps
interface dsl_sync_if;
  logic sclkFall;
  logic sclkRise;
  logic frameActive;
  logic frameEnd;
  logic loadFall;
  logic loadLevel;
  logic dataIn;
  logic clearActive;
  modport producer (output sclkFall, sclkRise, frameActive, frameEnd,
    loadFall, loadLevel, dataIn, clearActive);
  modport consumer (input sclkFall, sclkRise, frameActive, frameEnd,
    loadFall, loadLevel, dataIn, clearActive);
endinterface : dsl_sync_if

// ---- dsl_pin_sync.sv ----
// module: two-stage synchronisers and edge detection for pins
`timescale 1ns/10ps
module dsl_pin_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclkPin,
  input wire logic frameSelN,
  input wire logic loadN,
  input wire logic dataPin,
  input wire logic clearN,
  dsl_sync_if.producer sy
);
  logic [4:0] meta;
  logic [4:0] stable;
  logic [4:0] prev;
  logic [4:0] next_meta;
  logic [4:0] next_stable;
  logic [4:0] next_prev;

  // first stage feeds only the second stage
  always_comb begin
    next_meta = {clearN, dataPin, loadN, frameSelN, sclkPin};
    next_stable = meta;
    next_prev = stable;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= 5'h1f;
      stable <= 5'h1f;
      prev <= 5'h1f;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  // decoded levels from the stable stage only, edges from the stable and prev stages
  assign sy.sclkFall = prev[0] & ~stable[0];
  assign sy.sclkRise = ~prev[0] & stable[0];
  assign sy.frameActive = ~stable[1];
  assign sy.frameEnd = ~prev[1] & stable[1];
  assign sy.loadFall = prev[2] & ~stable[2];
  assign sy.loadLevel = stable[2];
  assign sy.dataIn = stable[3];
  assign sy.clearActive = ~stable[4];
endmodule : dsl_pin_sync

// ---- dac_serial_load_control.sv ----
// module: serial word capture, output load and clear for the DAC
// Summary of operation
// - reset low returns all state and output to power-up condition.
// - clear low loads clear value into DAC register and updates output.
// - clear value and output during clear follow current binary or twos coding.
// - load strobe held low: update output on frame select rising edge.
// - load strobe high during frame: update on next load strobe fall.
// - the serial input shift register is exactly 24 bits long.
// - data is sampled on each falling serial clock edge.
// - bits are accepted only while frame select is low.
// - serial output goes high impedance after frame select rises.
// - serial output bits change after rising serial clock edges.
`timescale 1ns/10ps
module dac_serial_load_control
  import dsl_pkg::*;
#(
  parameter int WORD_W = WORD_BITS,
  parameter int CODE_W = DAC_BITS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic resetN,
  input wire logic sclk,
  input wire logic frameSelN,
  input wire logic serial_in,
  input wire logic output_load_strobe_n,
  input wire logic force_preset_n,
  input wire logic twosCoding,
  input wire logic clearWrite,
  input wire logic [CODE_W-1:0] clearValue,
  input wire logic inputWrite,
  input wire logic [CODE_W-1:0] inputValue,
  input wire logic [WORD_W-1:0] readbackWord,
  output logic [WORD_W-1:0] frameWord,
  output logic frameWordValid,
  output logic [CODE_W-1:0] inputReg,
  output logic [CODE_W-1:0] dacReg,
  output logic dacUpdate,
  output logic serial_out,
  output logic serialOutEn
);
  initial begin
    if (WORD_W != WORD_BITS || CODE_W != DAC_BITS || CODE_W > WORD_W)
      $error("unsupported word or code width");
  end

  dsl_sync_if sy ();
  logic anyRst;
  logic resetMeta;
  logic resetMid;
  logic resetSync;
  logic frameBusyPrev;
  logic [WORD_W-1:0] shiftReg;
  logic [WORD_W-1:0] outShift;
  logic [CNT_BITS-1:0] bitCount;
  logic [CODE_W-1:0] clearReg;
  logic pendingLoad;
  logic next_frameBusyPrev;
  logic [WORD_W-1:0] next_shiftReg;
  logic [WORD_W-1:0] next_outShift;
  logic [CNT_BITS-1:0] next_bitCount;
  logic [WORD_W-1:0] next_frameWord;
  logic next_frameWordValid;
  logic [CODE_W-1:0] next_inputReg;
  logic [CODE_W-1:0] next_dacReg;
  logic [CODE_W-1:0] next_clearReg;
  logic next_pendingLoad;
  logic next_dacUpdate;
  logic next_serial_out;
  logic next_serialOutEn;
  logic [CODE_W-1:0] clearCode;

  // reset pin synchronised; it also acts asynchronously with rst
  assign anyRst = rst | ~resetN;

  // hold lasts until the pin edge detectors have seen two real samples,
  // so a pin idling away from its reset level gives no false edge
  always_ff @(posedge ref_clk or posedge anyRst) begin
    if (anyRst) begin
      resetMeta <= 1'b1;
      resetMid <= 1'b1;
      resetSync <= 1'b1;
    end else begin
      resetMeta <= 1'b0;
      resetMid <= resetMeta;
      resetSync <= resetMid;
    end
  end

  dsl_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(anyRst),
    .sclkPin(sclk),
    .frameSelN(frameSelN),
    .loadN(output_load_strobe_n),
    .dataPin(serial_in),
    .clearN(force_preset_n),
    .sy(sy.producer)
  );

  // clear value mapped into the coding in use
  always_comb begin
    clearCode = clearReg;
    if (twosCoding == DSL_CODE_TWOS)
      clearCode = clearReg ^ TWOS_OFFSET;
  end

  // shift, frame capture, load and clear next values
  always_comb begin
    next_frameBusyPrev = sy.frameActive;
    next_shiftReg = shiftReg;
    next_outShift = outShift;
    next_bitCount = bitCount;
    next_frameWord = frameWord;
    next_frameWordValid = 1'b0;
    next_inputReg = inputReg;
    next_dacReg = dacReg;
    next_clearReg = clearReg;
    next_pendingLoad = pendingLoad;
    next_dacUpdate = 1'b0;
    next_serial_out = serial_out;
    next_serialOutEn = serialOutEn;
    if (clearWrite)
      next_clearReg = clearValue;
    if (inputWrite) begin
      next_inputReg = inputValue;
      next_pendingLoad = 1'b1;
    end
    if (sy.frameActive && !frameBusyPrev) begin
      next_bitCount = '0;
      next_outShift = readbackWord;
    end
    if (sy.frameActive && sy.sclkFall) begin
      next_shiftReg = {shiftReg[WORD_W-2:0], sy.dataIn};
      if (bitCount != CNT_BITS'(WORD_W))
        next_bitCount = bitCount + CNT_BITS'(1);
    end
    if (sy.frameActive && sy.sclkRise) begin
      next_serialOutEn = 1'b1;
      next_serial_out = outShift[WORD_W-1];
      next_outShift = {outShift[WORD_W-2:0], 1'b0};
    end
    if (sy.frameEnd) begin
      next_serialOutEn = 1'b0;
      next_serial_out = 1'b0;
      next_frameWord = shiftReg;
      next_frameWordValid = 1'b1;
      next_inputReg = shiftReg[CODE_W-1:0];
      if (!sy.loadLevel) begin
        next_dacReg = shiftReg[CODE_W-1:0];
        next_dacUpdate = 1'b1;
        next_pendingLoad = 1'b0;
      end else
        next_pendingLoad = 1'b1;
    end
    if (sy.loadFall && !sy.frameEnd) begin
      next_dacReg = inputReg;
      next_dacUpdate = 1'b1;
      next_pendingLoad = 1'b0;
    end
    if (sy.clearActive) begin
      next_dacReg = clearCode;
      next_dacUpdate = 1'b1;
      next_pendingLoad = 1'b0;
    end
  end

  // every state returns to its power-up value under reset
  always_ff @(posedge ref_clk or posedge anyRst) begin
    if (anyRst) begin
      frameBusyPrev <= 1'b0;
      shiftReg <= '0;
      outShift <= '0;
      bitCount <= '0;
      frameWord <= '0;
      frameWordValid <= 1'b0;
      inputReg <= DAC_RESET_CODE;
      dacReg <= DAC_RESET_CODE;
      clearReg <= CLEAR_RESET_CODE;
      pendingLoad <= 1'b0;
      dacUpdate <= 1'b0;
      serial_out <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (resetSync) begin
      frameBusyPrev <= 1'b1; // no frame starts until pin is seen high
      dacUpdate <= 1'b0;
    end else begin
      frameBusyPrev <= next_frameBusyPrev;
      shiftReg <= next_shiftReg;
      outShift <= next_outShift;
      bitCount <= next_bitCount;
      frameWord <= next_frameWord;
      frameWordValid <= next_frameWordValid;
      inputReg <= next_inputReg;
      dacReg <= next_dacReg;
      clearReg <= next_clearReg;
      pendingLoad <= next_pendingLoad;
      dacUpdate <= next_dacUpdate;
      serial_out <= next_serial_out;
      serialOutEn <= next_serialOutEn;
    end
  end

  sequence frame_close;
    sy.frameEnd;
  endsequence

  chk_reset_output: assert property (@(posedge ref_clk)
    $rose(resetSync) |-> dacReg == DAC_RESET_CODE && !serialOutEn)
    else $error("state not at power-up value after reset");

  chk_clear_load: assert property (@(posedge ref_clk)
    disable iff (anyRst || resetSync) sy.clearActive |=> dacUpdate)
    else $error("clear did not update dac register");

  chk_clear_coding: assert property (@(posedge ref_clk)
    disable iff (anyRst || resetSync)
    sy.clearActive && !clearWrite |=> dacReg == $past(clearCode))
    else $error("clear code does not follow coding");

  chk_frame_load: assert property (@(posedge ref_clk)
    disable iff (anyRst || resetSync)
    frame_close ##0 !sy.loadLevel && !sy.clearActive
    |=> dacReg == $past(shiftReg[CODE_W-1:0]) && dacUpdate)
    else $error("frame end did not load dac register");

  chk_frame_hold: assert property (@(posedge ref_clk)
    disable iff (anyRst || resetSync)
    frame_close ##0 sy.loadLevel && !sy.clearActive && !sy.loadFall
    |=> pendingLoad && $stable(dacReg))
    else $error("dac register changed with load strobe high");

  chk_shift_in: assert property (@(posedge ref_clk)
    disable iff (anyRst || resetSync)
    sy.frameActive && sy.sclkFall
    |=> shiftReg[0] == $past(sy.dataIn))
    else $error("bit not sampled on falling edge");

  chk_idle_hold: assert property (@(posedge ref_clk)
    disable iff (anyRst || resetSync)
    !sy.frameActive |=> $stable(shiftReg))
    else $error("shift register moved outside frame");

  chk_out_release: assert property (@(posedge ref_clk)
    disable iff (anyRst || resetSync) frame_close |=> !serialOutEn)
    else $error("serial output not released");

  chk_word_pass: assert property (@(posedge ref_clk)
    disable iff (anyRst || resetSync)
    frame_close |=> frameWordValid && frameWord == $past(shiftReg))
    else $error("frame word not passed on");
endmodule : dac_serial_load_control

// ---- dsl_host_model.sv ----
// host serial master model that writes frames into the load control block
`timescale 1ns/10ps
module dsl_host_model (
  input wire logic ref_clk,
  input wire logic serial_out,
  output logic sclk,
  output logic frameSelN,
  output logic serial_in,
  output logic [23:0] rxWord
);
  // link clock idles low and stands still between frames
  initial begin
    sclk = 1'b0;
    frameSelN = 1'b1;
    serial_in = 1'b0;
    rxWord = 24'h00_0000;
  end
  // half of an 80 ns period, well under either link rate limit
  task automatic half_period();
    repeat (4) @(posedge ref_clk);
  endtask : half_period
  // one frame of 32 bits msb first; readback is captured on falling edges
  task automatic send(input logic [31:0] word);
    @(posedge ref_clk);
    frameSelN <= 1'b0;
    half_period();
    for (int i = 31; i >= 0; i--) begin
      serial_in <= word[i];
      sclk <= 1'b1;
      half_period();
      sclk <= 1'b0;
      if (i >= 8) begin
        rxWord <= {rxWord[22:0], serial_out};
      end
      half_period();
    end
    frameSelN <= 1'b1;
    serial_in <= ~word[0]; // released data line shows no stale value
  endtask : send
endmodule : dsl_host_model

// ---- tb.sv ----
// self-checking testbench for the serial load control block
`timescale 1ns/10ps
module tb;
  import dsl_pkg::*;
  logic ref_clk, rst, resetN, output_load_strobe_n, force_preset_n;
  logic twosCoding, clearWrite, inputWrite, sclk, frameSelN, serial_in;
  logic frameWordValid, dacUpdate, serial_out, serialOutEn;
  logic [19:0] clearValue, inputValue, inputReg, dacReg;
  logic [23:0] readbackWord, frameWord, rxWord;
  int errTotal = 0;
  int nCompared = 0;
  int validSeen = 0;
  int updSeen = 0;

  dac_serial_load_control dac_serial_load_control_inst (.ref_clk, .rst,
    .resetN, .sclk, .frameSelN, .serial_in, .output_load_strobe_n,
    .force_preset_n, .twosCoding, .clearWrite, .clearValue, .inputWrite,
    .inputValue, .readbackWord, .frameWord, .frameWordValid, .inputReg,
    .dacReg, .dacUpdate, .serial_out, .serialOutEn);
  dsl_host_model dsl_host_model_inst (.ref_clk, .serial_out, .sclk,
    .frameSelN, .serial_in, .rxWord);

  // 100 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // count the one-cycle pulses
  always @(posedge ref_clk) begin
    if (frameWordValid === 1'b1) validSeen++;
    if (dacUpdate === 1'b1) updSeen++;
  end

  task automatic chk(input logic ok, input string msg);
    nCompared++;
    if (ok !== 1'b1) begin
      errTotal++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // one frame, then a bounded wait for the word to be handed on
  task automatic frame(input logic [31:0] word);
    validSeen = 0;
    updSeen = 0;
    dsl_host_model_inst.send(word);
    for (int i = 0; i < 30 && validSeen == 0; i++) cyc(1);
    cyc(3);
    @(negedge ref_clk);
  endtask : frame
  task automatic t_reset_state();
    @(negedge ref_clk);
    chk(dacReg === 20'h0_0000 && inputReg === 20'h0_0000, "reset regs");
    chk(frameWord === 24'h00_0000 && serialOutEn === 1'b0, "reset out");
  endtask : t_reset_state
  // strobe held low: back-to-back frames update the dac at frame end
  task automatic t_direct();
    logic [31:0] words [2];
    words = '{32'h5AF0_1234, 32'hFFFF_FFFF};
    for (int k = 0; k < 2; k++) begin
      readbackWord <= words[1 - k][27:4];
      cyc(1);
      frame(words[k]);
      chk(frameWord === words[k][23:0], "frame word");
      chk(validSeen == 1, "valid pulse");
      chk(inputReg === words[k][19:0], "input reg");
      chk(dacReg === words[k][19:0] && updSeen == 1, "dac load");
      chk(rxWord === words[1 - k][27:4], "readback");
      chk(serialOutEn === 1'b0, "serial out not released");
    end
  endtask : t_direct
  // strobe high: only the input register moves until the strobe falls
  task automatic t_deferred();
    output_load_strobe_n <= 1'b1;
    frame(32'h1357_9BDF);
    chk(inputReg === 20'h7_9BDF, "deferred input");
    chk(dacReg === 20'hF_FFFF && updSeen == 0, "early dac load");
    output_load_strobe_n <= 1'b0;
    cyc(8);
    chk(dacReg === 20'h7_9BDF, "strobe load");
    output_load_strobe_n <= 1'b1;
    inputValue <= 20'h2_4680;
    inputWrite <= 1'b1;
    cyc(1);
    inputWrite <= 1'b0;
    cyc(2);
    chk(dacReg === 20'h7_9BDF, "input write loaded dac");
    output_load_strobe_n <= 1'b0;
    cyc(8);
    chk(dacReg === 20'h2_4680, "input write load");
  endtask : t_deferred
  // clear in both codings, and a frame while clear is held
  task automatic t_clear();
    clearValue <= 20'h1_2345;
    clearWrite <= 1'b1;
    cyc(1);
    clearWrite <= 1'b0;
    force_preset_n <= 1'b0;
    cyc(6);
    chk(dacReg === 20'h1_2345, "binary clear");
    twosCoding <= 1'b1;
    cyc(6);
    chk(dacReg === (20'h1_2345 ^ TWOS_OFFSET), "twos clear");
    frame(32'h0000_0F0F);
    chk(dacReg === (20'h1_2345 ^ TWOS_OFFSET), "frame beat clear");
    force_preset_n <= 1'b1;
    twosCoding <= 1'b0;
    cyc(4);
  endtask : t_clear
  // device reset pin mid-run returns everything to power-up state
  task automatic t_pin_reset();
    frame(32'h0000_0001);
    resetN <= 1'b0;
    cyc(2);
    t_reset_state();
    resetN <= 1'b1;
    cyc(4);
  endtask : t_pin_reset

  task automatic finishTest();
    $display("comparisons %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finishTest
  // cut a hang short
  initial begin
    cyc(20000);
    errTotal++;
    $display("mismatch at %0t: watchdog expired", $time);
    finishTest();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    resetN = 1'b1;
    output_load_strobe_n = 1'b0;
    force_preset_n = 1'b1;
    twosCoding = 1'b0;
    clearWrite = 1'b0;
    inputWrite = 1'b0;
    clearValue = 20'h0_0000;
    inputValue = 20'h0_0000;
    readbackWord = 24'h00_0000;
    cyc(4);
    rst <= 1'b0;
    cyc(4);
    t_reset_state();
    t_direct();
    t_deferred();
    t_clear();
    t_pin_reset();
    finishTest();
  end
endmodule : tb
